//--- rtl/cap_touch_consts.svh
// Offsets, field positions, reset values and timing counts of the touch host block
`ifndef CAP_TOUCH_CONSTS_SVH
`define CAP_TOUCH_CONSTS_SVH

`define SETUP_OFF       12'h168
`define ENGRST_OFF      12'h180
`define IRQ_STAT_OFF    12'h184
`define IRQ_MASK_OFF    12'h188
`define PIN_OFF         12'h18c
`define STATUS_OFF      12'h190
`define REPORT_OFF      12'h194

`define SETUP_RESET     32'h0000_0381
`define SETUP_RW_MASK   16'h9fff
`define ENGRST_HOLD_BIT 1
`define FIXED_ADDR      7'h38
`define ADDR_BYTE_W     8'h70
`define ADDR_BYTE_R     8'h71

`define IRQ_REPORT      0
`define IRQ_NACK        1
`define IRQ_SHORT       2
`define IRQ_TOUCH       3

`define CLK_PERIOD_NS   100
`define QUARTER_NS      2500
`define QUARTER_CYC     ((`QUARTER_NS) / (`CLK_PERIOD_NS))
`define PANEL_RST_NS    100000
`define PANEL_RST_CYC   ((`PANEL_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_MS      300
`define STARTUP_CYC     ((`STARTUP_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INT_PULSE_NS    45000

`endif

//--- rtl/cap_touch_pkg.sv
// Types shared by the touch host block
package cap_touch_pkg;

	typedef enum {E_HOLD, E_CTPRST, E_BOOT, E_IDLE, E_START, E_BYTE, E_STOP} eng_state_e;

	typedef struct packed {
		logic       resistive;
		logic [1:0] rsv;
		logic       ignore_short;
		logic       low_power;
		logic [6:0] addr;
		logic       family;
		logic       no_startup;
		logic [1:0] sampler;
	} setup_s;

	typedef struct packed {
		logic touch;
		logic short_err;
		logic nack;
		logic report;
	} irq_s;

endpackage : cap_touch_pkg

//--- rtl/cap_touch_host_setup.sv
// Touch engine: I2C master to a capacitive touch controller, APB registers
//
// Behaviour
// - Fixed-address variant always talks to slave address 0x38.
// - Fixed address goes out as byte 0x70 for write, 0x71 for read.
// - Configurable variant uses setup bits 10..4 as slave address.
// - Setup bit 15: zero capacitive, one resistive engine.
// - Bit 12 ignores a short circuit, bit 11 enables low-power mode.
// - Bit 3 picks the controller family protocol.
// - Bit 2 skips the 300 ms startup; bits 1..0 give sampler clocks.
// - Bits 31..16 and 14..13 are reserved without function.
// - Controller start-up and reads run in hardware, no software help.
// - Interrupt pulses down to 45 us are caught, none lost.
// - Third family interrupts accepted as rising or falling pulses.
// - Only trigger interrupt mode and standard I2C protocol.
//
// Our own choice: register access over APB.
`include "cap_touch_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module cap_touch_host_setup #(
	parameter logic [31:0] SETUP_RESET     = `SETUP_RESET,
	parameter bit          FIXED_ADDR_ONLY = 1'b0,
	parameter int          STARTUP_CYC     = `STARTUP_CYC,
	parameter int          REPORT_BYTES    = 4,
	parameter logic [7:0]  PTR_F0          = 8'h00,
	parameter logic [15:0] PTR_F1          = 16'h0000
) (
	input  wire logic        mclk_i,       // System clock
	input  wire logic        rst_n_i,      // Synchronous reset
	input  wire logic [11:0] paddr_i,      // APB address
	input  wire logic        psel_i,       // APB select
	input  wire logic        penable_i,    // APB enable
	input  wire logic        pwrite_i,     // APB direction
	input  wire logic [31:0] pwdata_i,     // APB write data
	output logic      [31:0] prdata_o,     // APB read data
	output logic             pready_o,     // APB ready
	output logic             pslverr_o,    // APB error
	input  wire logic        scl_i,        // I2C clock level
	output logic             scl_o,        // I2C clock out
	output logic             scl_oe_n_o,   // I2C clock pull low
	input  wire logic        sda_i,        // I2C data level
	output logic             sda_o,        // I2C data out
	output logic             sda_oe_n_o,   // I2C data pull low
	output logic             panel_rst_n_o,   // Controller reset
	input  wire logic        panel_int_i,     // Controller interrupt
	input  wire logic        pin_zero_i,      // General pin level
	output logic             pin_zero_o,      // General pin value
	output logic             pin_zero_oe_n_o, // General pin drive
	output logic             irq_o         // Interrupt request
);

	localparam logic [31:0] RST_CYC  = 32'(`PANEL_RST_CYC);
	localparam logic [7:0]  QTR_CYC  = 8'(`QUARTER_CYC);

	cap_touch_pkg::eng_state_e st;
	cap_touch_pkg::setup_s     setup;
	cap_touch_pkg::setup_s     cfg;
	cap_touch_pkg::irq_s       stat;
	cap_touch_pkg::irq_s       mask;
	cap_touch_pkg::irq_s       ev;
	logic [1:0]  engrst;
	logic [3:0]  pin_s1;
	logic [3:0]  pin_s2;
	logic        scl_s;
	logic        sda_s;
	logic        int_s;
	logic        access;
	logic        wr_go;
	logic [31:0] rd_val;
	logic        rd_ok;
	logic [7:0]  qcnt;
	logic        tick;
	logic [31:0] wcnt;
	logic [1:0]  q;
	logic [3:0]  bitn;
	logic [1:0]  seq;
	logic        rd_phase;
	logic        rx;
	logic [7:0]  sh;
	logic [7:0]  bleft;
	logic [31:0] report;
	logic        short_lock;
	logic        int_lvl;
	logic        int_idle;
	logic [1:0]  fcnt;
	logic        int_flip;
	logic        int_pend;
	logic        ev_int;
	logic        bus_low;
	logic        live;
	logic        ev_report;
	logic        ev_nack;
	logic        ev_short;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pin_s1 <= 4'hf;
			pin_s2 <= 4'hf;
		end else begin
			pin_s1 <= {pin_zero_i, panel_int_i, sda_i, scl_i};
			pin_s2 <= pin_s1;
		end
	end

	assign scl_s   = pin_s2[0];
	assign sda_s   = pin_s2[1];
	assign int_s   = pin_s2[2];
	assign bus_low = !scl_s || !sda_s;
	assign live    = (st != cap_touch_pkg::E_HOLD) && (st != cap_touch_pkg::E_CTPRST)
		&& (st != cap_touch_pkg::E_BOOT);

	////////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state

	assign access = psel_i && penable_i && !pready_o;
	assign wr_go  = psel_i && penable_i && pready_o && pwrite_i;

	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		if (paddr_i == `SETUP_OFF) begin
			rd_val = {16'h0000, setup & `SETUP_RW_MASK};
		end else if (paddr_i == `ENGRST_OFF) begin
			rd_val = {30'h0000_0000, engrst};
		end else if (paddr_i == `IRQ_STAT_OFF) begin
			rd_val = {28'h000_0000, stat};
		end else if (paddr_i == `IRQ_MASK_OFF) begin
			rd_val = {28'h000_0000, mask};
		end else if (paddr_i == `PIN_OFF) begin
			rd_val = {29'h0000_0000, pin_s2[3], !pin_zero_oe_n_o, pin_zero_o};
		end else if (paddr_i == `STATUS_OFF) begin
			rd_val = {24'h00_0000, short_lock, int_lvl, int_pend, 1'b0, 4'(st)};
		end else if (paddr_i == `REPORT_OFF) begin
			rd_val = report;
		end else begin
			rd_ok  = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o  <= access;
			pslverr_o <= access && !rd_ok;
			prdata_o  <= (access && !pwrite_i) ? rd_val : 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			setup        <= SETUP_RESET[15:0];
			engrst       <= 2'h0;
			mask         <= 4'h0;
			pin_zero_o      <= 1'b0;
			pin_zero_oe_n_o <= 1'b1;
		end else if (wr_go) begin
			if (paddr_i == `SETUP_OFF)
				setup <= pwdata_i[15:0] & `SETUP_RW_MASK;
			else if (paddr_i == `ENGRST_OFF)
				engrst <= pwdata_i[1:0];
			else if (paddr_i == `IRQ_MASK_OFF)
				mask <= pwdata_i[3:0];
			else if (paddr_i == `PIN_OFF) begin
				pin_zero_o      <= pwdata_i[0];
				pin_zero_oe_n_o <= !pwdata_i[1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky events, write one to clear; a new event wins

	assign ev = '{touch: ev_int, short_err: ev_short, nack: ev_nack, report: ev_report};

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			stat  <= 4'h0;
			irq_o <= 1'b0;
		end else begin
			stat  <= (stat & ~((wr_go && paddr_i == `IRQ_STAT_OFF) ? pwdata_i[3:0] : 4'h0)) | ev;
			irq_o <= |(stat & mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt filter and capture

	assign int_flip = (int_s != int_lvl) && (fcnt == cfg.sampler);

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			int_lvl  <= 1'b1;
			fcnt     <= 2'h0;
			ev_int   <= 1'b0;
			int_pend <= 1'b0;
		end else begin
			if (int_s == int_lvl)
				fcnt <= 2'h0;
			else if (int_flip) begin
				int_lvl <= int_s;
				fcnt    <= 2'h0;
			end else
				fcnt <= fcnt + 2'h1;
			ev_int <= live && int_flip && (int_s != int_idle);
			if (ev_int)
				int_pend <= 1'b1;
			else if (st == cap_touch_pkg::E_START && !rd_phase && tick && q == 2'h3)
				int_pend <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Quarter-bit timer; low power halves the bus rate

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			qcnt <= 8'h00;
			tick <= 1'b0;
		end else if (qcnt == 8'h00) begin
			qcnt <= cfg.low_power ? 8'((QTR_CYC << 1) - 8'h01) : QTR_CYC - 8'h01;
			tick <= 1'b1;
		end else begin
			qcnt <= qcnt - 8'h01;
			tick <= 1'b0;
		end
	end

	function automatic logic [7:0] tx_byte(input logic [1:0] s, input logic [6:0] a);
		logic [7:0] b;
		b = 8'h00;
		case (s)
			2'h0: b = FIXED_ADDR_ONLY ? `ADDR_BYTE_W : {a, 1'b0};
			2'h1: b = PTR_F1[15:8];
			2'h2: b = cfg.family ? PTR_F1[7:0] : PTR_F0;
			default: b = FIXED_ADDR_ONLY ? `ADDR_BYTE_R : {a, 1'b1};
		endcase
		return b;
	endfunction : tx_byte

	////////////////////////////////////////////////////////////////////////////
	// Engine sequencer and I2C bit engine

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st             <= cap_touch_pkg::E_HOLD;
			cfg            <= 16'h0000;
			wcnt           <= 32'h0000_0000;
			q              <= 2'h0;
			bitn           <= 4'h0;
			seq            <= 2'h0;
			rd_phase       <= 1'b0;
			rx             <= 1'b0;
			sh             <= 8'h00;
			bleft          <= 8'h00;
			report         <= 32'h0000_0000;
			scl_oe_n_o     <= 1'b1;
			sda_oe_n_o     <= 1'b1;
			short_lock     <= 1'b0;
			int_idle       <= 1'b1;
			ev_report      <= 1'b0;
			ev_nack        <= 1'b0;
			ev_short       <= 1'b0;
		end else begin
			ev_report <= 1'b0;
			ev_nack   <= 1'b0;
			ev_short  <= 1'b0;
			if (engrst[`ENGRST_HOLD_BIT]) begin
				st         <= cap_touch_pkg::E_HOLD;
				scl_oe_n_o <= 1'b1;
				sda_oe_n_o <= 1'b1;
				short_lock <= 1'b0;
				rx         <= 1'b0;
			end else begin
				case (st)
				cap_touch_pkg::E_HOLD: begin
					cfg  <= setup;
					if (FIXED_ADDR_ONLY)
						cfg.addr <= `FIXED_ADDR;
					wcnt <= RST_CYC;
					st   <= cap_touch_pkg::E_CTPRST;
				end
				cap_touch_pkg::E_CTPRST: begin
					if (wcnt == 32'h1) begin
						wcnt <= cfg.no_startup ? 32'h1 : 32'(STARTUP_CYC);
						st   <= cap_touch_pkg::E_BOOT;
					end else
						wcnt <= wcnt - 32'h1;
				end
				cap_touch_pkg::E_BOOT: begin
					if (wcnt == 32'h1) begin
						int_idle <= int_lvl;
						st       <= cap_touch_pkg::E_IDLE;
					end else
						wcnt <= wcnt - 32'h1;
				end
				cap_touch_pkg::E_IDLE: begin
					if (tick && bus_low && !short_lock && !cfg.ignore_short) begin
						short_lock <= 1'b1;
						ev_short   <= 1'b1;
					end else if (tick && !bus_low && int_pend && !short_lock
						&& !cfg.resistive) begin
						st       <= cap_touch_pkg::E_START;
						q        <= 2'h0;
						rd_phase <= 1'b0;
					end
				end
				cap_touch_pkg::E_START: if (tick) begin
					q <= q + 2'h1;
					case (q)
					2'h0: begin
						sda_oe_n_o <= 1'b1;
						// Repeated start: SCL pulled low in the same tick that SDA is released
						if (rd_phase)
							scl_oe_n_o <= 1'b0;
					end
					2'h1: scl_oe_n_o <= 1'b1;
					2'h2: sda_oe_n_o <= 1'b0;
					default: begin
						scl_oe_n_o <= 1'b0;
						seq        <= rd_phase ? 2'h3 : 2'h0;
						sh         <= tx_byte(rd_phase ? 2'h3 : 2'h0, cfg.addr);
						bitn       <= 4'h0;
						st         <= cap_touch_pkg::E_BYTE;
					end
					endcase
				end
				cap_touch_pkg::E_BYTE: if (tick) begin
					case (q)
					2'h0: begin
						scl_oe_n_o <= 1'b0;
						q          <= 2'h1;
					end
					2'h1: begin
						if (rx)
							sda_oe_n_o <= !(bitn == 4'h8 && bleft != 8'h01);
						else
							sda_oe_n_o <= (bitn == 4'h8) ? 1'b1 : sh[7];
						q <= 2'h2;
					end
					2'h2: begin
						scl_oe_n_o <= 1'b1;
						q          <= 2'h3;
					end
					default: if (scl_s) begin
						q <= 2'h0;
						if (bitn != 4'h8) begin
							sh   <= {sh[6:0], sda_s};
							bitn <= bitn + 4'h1;
						end else if (!rx && sda_s) begin
							ev_nack <= 1'b1;
							st      <= cap_touch_pkg::E_STOP;
						end else if (rx) begin
							report <= {report[23:0], sh};
							bitn   <= 4'h0;
							bleft  <= bleft - 8'h01;
							if (bleft == 8'h01)
								st <= cap_touch_pkg::E_STOP;
						end else if (seq == 2'h0 || seq == 2'h1) begin
							seq  <= (seq == 2'h0 && cfg.family) ? 2'h1 : 2'h2;
							sh   <= tx_byte((seq == 2'h0 && cfg.family) ? 2'h1 : 2'h2, cfg.addr);
							bitn <= 4'h0;
						end else if (seq == 2'h2) begin
							rd_phase <= 1'b1;
							st       <= cap_touch_pkg::E_START;
						end else begin
							rx    <= 1'b1;
							bleft <= 8'(REPORT_BYTES);
							bitn  <= 4'h0;
						end
					end
					endcase
				end
				default: if (tick) begin
					q <= q + 2'h1;
					case (q)
					2'h0: scl_oe_n_o <= 1'b0;
					2'h1: sda_oe_n_o <= 1'b0;
					2'h2: scl_oe_n_o <= 1'b1;
					default: begin
						sda_oe_n_o <= 1'b1;
						ev_report  <= rx;
						rx         <= 1'b0;
						st         <= cap_touch_pkg::E_IDLE;
					end
					endcase
				end
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			panel_rst_n_o <= 1'b0;
			scl_o         <= 1'b0;
			sda_o         <= 1'b0;
		end else begin
			panel_rst_n_o <= live;
			scl_o         <= 1'b0;
			sda_o         <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	logic addr_slot;
	assign addr_slot = st == cap_touch_pkg::E_BYTE && bitn == 4'h0 && q == 2'h0 && !rx;

	property p_fixed_addr;
		FIXED_ADDR_ONLY && addr_slot && seq == 2'h0 |-> sh == `ADDR_BYTE_W;
	endproperty
	a_fixed_addr: assert property (p_fixed_addr) else $error("fixed write address wrong");
	property p_cfg_addr;
		!FIXED_ADDR_ONLY && addr_slot && seq[0] == seq[1] |-> sh[7:1] == cfg.addr && sh[0] == seq[0];
	endproperty
	a_cfg_addr: assert property (p_cfg_addr) else $error("slave address not from setup");
	property p_resistive;
		cfg.resistive && st == cap_touch_pkg::E_IDLE |=> st != cap_touch_pkg::E_START;
	endproperty
	a_resistive: assert property (p_resistive) else $error("resistive engine started a read");
	property p_short;
		short_lock |-> st != cap_touch_pkg::E_START;
	endproperty
	a_short: assert property (p_short) else $error("transfer after short circuit");
	property p_family;
		st == cap_touch_pkg::E_BYTE && seq == 2'h1 |-> cfg.family;
	endproperty
	a_family: assert property (p_family) else $error("wide pointer on first family");
	property p_nostart;
		st == cap_touch_pkg::E_CTPRST && wcnt == 32'h1 && cfg.no_startup
			|=> ##1 st == cap_touch_pkg::E_IDLE;
	endproperty
	a_nostart: assert property (p_nostart) else $error("startup not suppressed");
	property p_rsv;
		pready_o && !pwrite_i && paddr_i == `SETUP_OFF |-> prdata_o[31:16] == 16'h0000
			&& prdata_o[14:13] == 2'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved setup bits read nonzero");
	property p_hold;
		engrst[`ENGRST_HOLD_BIT] |=> st == cap_touch_pkg::E_HOLD ##1 !panel_rst_n_o;
	endproperty
	a_hold: assert property (p_hold) else $error("engine not held in reset");
	property p_catch;
		ev_int |=> int_pend && stat.touch;
	endproperty
	a_catch: assert property (p_catch) else $error("interrupt pulse lost");

	c_report: cover property (ev_report);
	c_nack: cover property (ev_nack);
	c_short: cover property (ev_short);

endmodule : cap_touch_host_setup

`default_nettype wire

//--- bench/ctp_model.sv
// Behavioural touch controller on the I2C lines
`timescale 1ns/1ns
`default_nettype none

module touch_panel_model (
	input  wire logic scl_i,  // Bus clock level
	input  wire logic sda_i,  // Bus data level
	output logic      pull_o, // Pulls data low
	output logic      int_o   // Report interrupt
);
	logic [6:0] addr;
	logic [7:0] sh, tx, log_q[$];
	int         bitn;
	logic       sel, rd, rdg, mack, first;

	initial begin
		addr = 7'h38;
		pull_o = 1'b0;
		int_o = 1'b1;
		bitn = 0;
		first = 1'b0;
		rdg = 1'b0;
		sel = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	always @(negedge sda_i) if (scl_i === 1'b1) begin
		bitn = 0;
		first = 1'b1;
		rdg = 1'b0;
		tx = 8'ha0;
	end

	always @(posedge sda_i) if (scl_i === 1'b1) begin
		sel = 1'b0;
		rdg = 1'b0;
	end

	always @(posedge scl_i) begin
		if (bitn < 8)
			sh = {sh[6:0], sda_i};
		else
			mack = ~sda_i;
		bitn++;
	end

	// Acks own address and written bytes, shifts out read bytes
	always @(negedge scl_i) begin
		if (bitn == 8) begin
			if (first) begin
				sel = (sh[7:1] == addr);
				rd = sh[0];
				first = 1'b0;
			end
			if (!rdg)
				log_q.push_back(sh);
			pull_o = sel & ~rdg;
		end else if (bitn == 9) begin
			bitn = 0;
			if (rdg)
				tx = tx + 8'h01;
			rdg = sel & rd & (rdg ? mack : 1'b1);
			pull_o = rdg & ~tx[7];
		end else if (rdg && bitn > 0)
			pull_o = ~tx[7 - bitn];
	end

	task pulse(input int ns);
		int_o = ~int_o;
		#(ns);
		int_o = ~int_o;
	endtask : pulse

endmodule : touch_panel_model
`default_nettype wire

//--- bench/cap_touch_host_setup_tb.sv
// Self-checking bench of the touch host block
`timescale 1ns/1ns
`default_nettype none
`include "cap_touch_consts.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", n, e, g); end end

module cap_touch_host_setup_tb;
	logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, err_b;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        scl_oe_n, sda_oe_n, gp_v, gp_oe_n, irq, pull, int_l, scl_v, sda_v, prst_n;
	int          err_count, checks, cyc;
	wire         scl_w = scl_oe_n;
	wire         sda_w = sda_oe_n & ~pull;
	wire         gp_w  = gp_oe_n | gp_v;

	cap_touch_host_setup #(.STARTUP_CYC(50)) uut (
		.mclk_i(mclk), .rst_n_i(rst_n), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .scl_i(scl_w), .scl_o(scl_v),
		.scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_v), .sda_oe_n_o(sda_oe_n),
		.panel_rst_n_o(prst_n), .panel_int_i(int_l), .pin_zero_i(gp_w), .pin_zero_o(gp_v),
		.pin_zero_oe_n_o(gp_oe_n), .irq_o(irq));

	touch_panel_model panel (.scl_i(scl_w), .sda_i(sda_w), .pull_o(pull), .int_o(int_l));

	////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			err_count++;
			close_out();
		end
	end

	task automatic close_out();
		if (err_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		q = prdata;
		err_b = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((q & m) !== v && n < 3000);
		`CHK("poll", v, q & m)
	endtask : poll

	task automatic t_regs();
		apb(1'b0, `SETUP_OFF, 32'h0);
		`CHK("setup reset", `SETUP_RESET, q)
		apb(1'b1, `SETUP_OFF, 32'hffff_ffff);
		apb(1'b0, `SETUP_OFF, 32'h0);
		`CHK("setup rsv", 32'h0000_9fff, q)
		apb(1'b0, 12'h100, 32'h0);
		`CHK("unmapped", 1'b1, err_b)
		`CHK("scl data", 1'b0, scl_v)
		`CHK("sda data", 1'b0, sda_v)
		apb(1'b1, `SETUP_OFF, `SETUP_RESET);
	endtask : t_regs

	task automatic t_report();
		poll(`STATUS_OFF, 32'hf, 32'h3);
		panel.pulse(45000);
		poll(`IRQ_STAT_OFF, 32'h1, 32'h1);
		`CHK("irq masked", 1'b0, irq)
		`CHK("addr w", 8'h70, panel.log_q[0])
		`CHK("ptr", 8'h00, panel.log_q[1])
		`CHK("addr r", 8'h71, panel.log_q[2])
		apb(1'b0, `REPORT_OFF, 32'h0);
		`CHK("report", 32'ha0a1a2a3, q)
		apb(1'b1, `IRQ_MASK_OFF, 32'h1);
		repeat (2) @(posedge mclk);
		`CHK("irq on", 1'b1, irq)
		apb(1'b1, `IRQ_STAT_OFF, 32'hf);
		repeat (2) @(posedge mclk);
		`CHK("irq off", 1'b0, irq)
		panel.log_q.delete();
	endtask : t_report

	task automatic t_addr();
		apb(1'b1, `SETUP_OFF, 32'h0000_02ad);
		panel.addr = 7'h2a;
		panel.pulse(45000);
		poll(`IRQ_STAT_OFF, 32'h2, 32'h2);
		`CHK("old addr", 8'h70, panel.log_q[0])
		apb(1'b1, `ENGRST_OFF, 32'h2);
		apb(1'b1, `ENGRST_OFF, 32'h0);
		panel.log_q.delete();
		poll(`STATUS_OFF, 32'hf, 32'h3);
		panel.pulse(45000);
		poll(`IRQ_STAT_OFF, 32'h1, 32'h1);
		`CHK("new addr", 8'h54, panel.log_q[0])
		`CHK("ptr hi", 8'h00, panel.log_q[1])
		`CHK("ptr lo", 8'h00, panel.log_q[2])
		`CHK("addr rd", 8'h55, panel.log_q[3])
		apb(1'b1, `IRQ_STAT_OFF, 32'hf);
	endtask : t_addr

	task automatic t_third();
		poll(`STATUS_OFF, 32'hf, 32'h3);
		apb(1'b1, `ENGRST_OFF, 32'h2);
		apb(1'b1, `SETUP_OFF, 32'h0000_05d0);
		apb(1'b1, `PIN_OFF, 32'h2);
		repeat (2) @(posedge mclk);
		`CHK("pin low", 1'b0, gp_w)
		`CHK("panel held", 1'b0, prst_n)
		repeat (1001) @(posedge mclk);
		apb(1'b0, `PIN_OFF, 32'h0);
		`CHK("pin reg", 32'h0000_0002, q)
		panel.int_o = 1'b0;
		panel.addr = 7'h5d;
		panel.log_q.delete();
		apb(1'b1, `ENGRST_OFF, 32'h0);
		// Settle wait shortened, startup count is scaled down
		repeat (1200) @(posedge mclk);
		apb(1'b1, `PIN_OFF, 32'h0);
		repeat (2) @(posedge mclk);
		`CHK("pin float", 1'b1, gp_oe_n)
		poll(`STATUS_OFF, 32'hf, 32'h3);
		`CHK("panel run", 1'b1, prst_n)
		panel.pulse(45000);
		poll(`IRQ_STAT_OFF, 32'h1, 32'h1);
		`CHK("third addr", 8'hba, panel.log_q[0])
		apb(1'b1, `IRQ_STAT_OFF, 32'hf);
	endtask : t_third

	task automatic t_resist();
		apb(1'b1, `ENGRST_OFF, 32'h2);
		apb(1'b1, `SETUP_OFF, 32'h0000_8385);
		apb(1'b1, `ENGRST_OFF, 32'h0);
		panel.log_q.delete();
		repeat (1200) @(posedge mclk);
		panel.pulse(45000);
		repeat (12000) @(posedge mclk);
		`CHK("no traffic", 0, panel.log_q.size())
		apb(1'b0, `IRQ_STAT_OFF, 32'h0);
		`CHK("no report", 1'b0, q[0])
	endtask : t_resist

	////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		t_report();
		t_addr();
		t_third();
		t_resist();
		close_out();
	end

endmodule : cap_touch_host_setup_tb
`default_nettype wire
